// >>> i3tr_pkg.sv
// Purpose: shared constants of the target status and event register bank
// Assumes: 40 MHz core clock, APB with one aligned 32-bit word per register
// Notes:   register indices times four give byte addresses
package i3tr_pkg;
   localparam int CLK_PERIOD_NS = 25;
   // bus condition timings, plain defaults
   localparam int AVAL_TIME_NS  = 1000;
   localparam int IDLE_TIME_US  = 200;
   localparam int AVAL_CYC      = (AVAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int IDLE_CYC_DEF  = (IDLE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // register indices
   localparam logic [5:0] IDX_RESP       = 6'h29;
   localparam logic [5:0] IDX_STAT_HI    = 6'h2A;
   localparam logic [5:0] IDX_STAT_LO    = 6'h2B;
   localparam logic [5:0] IDX_ACT        = 6'h2C;
   localparam logic [5:0] IDX_RST_BYTE   = 6'h2D;
   localparam logic [5:0] IDX_RST_ORIGIN = 6'h2E;
   localparam logic [5:0] IDX_RST_DIRECT = 6'h2F;
   localparam logic [5:0] IDX_FLAGS1     = 6'h30;
   localparam logic [5:0] IDX_MASK1      = 6'h31;
   localparam logic [5:0] IDX_FORCE1     = 6'h32;
   localparam logic [5:0] IDX_FLAGS2     = 6'h33;
   localparam logic [5:0] IDX_MASK2      = 6'h34;
   localparam logic [5:0] IDX_FORCE2     = 6'h35;
   localparam logic [5:0] IDX_FLAGS3     = 6'h36;
   localparam logic [5:0] IDX_MASK3      = 6'h37;
   localparam logic [5:0] IDX_FORCE3     = 6'h38;

   // field positions
   localparam int RESP_LOOPBACK_BIT = 4;
   localparam int RESP_NAK_BIT      = 0;
   localparam logic [7:0] RESP_MASK    = 8'h11;
   localparam logic [7:0] STAT_LO_MASK = 8'hCF;
   localparam int F1_IBI_DONE       = 2;
   localparam int F2_RD_TX_EMPTY    = 3;
   localparam int F3_RST_PATTERN    = 6;
   localparam int F3_RSTACT         = 5;
   localparam int F3_ACTIVITY       = 4;
   localparam int F3_BUS_AVAL       = 1;
   localparam int F3_BUS_IDLE       = 0;
   localparam logic [7:0] GRP1_MASK = 8'hEF;
   localparam logic [7:0] GRP2_MASK = 8'hEF;
   localparam logic [7:0] GRP3_MASK = 8'hFB;

   // reset values and empty-read fill bytes
   localparam logic [7:0] RST_DIRECT_RESET = 8'h80;
   localparam logic [7:0] SDR_EMPTY_FILL   = 8'hFF;
   localparam logic [7:0] DDR_EMPTY_FILL   = 8'h00;
endpackage : i3tr_pkg

// >>> i3tr_regs.sv
// Purpose: status, response and event register bank of an I3C target
// Assumes: bus engine strobes are one pclk cycle wide and synchronous to pclk
// Notes:   scl/sda pins pass a two-flop synchroniser before the idle detector
`timescale 1ns/100ps
module i3tr_regs
   import i3tr_pkg::*;
#(
   parameter int IDLE_CYC = IDLE_CYC_DEF
) (
   // clock, reset, enable
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       ce,
   // apb slave
   input  wire logic       psel,
   input  wire logic       penable,
   input  wire logic       pwrite,
   input  wire logic [7:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]     prdata,
   output logic            pready,
   output logic            pslverr,
   // bus pins, observed only
   input  wire logic       scl_i,
   input  wire logic       sda_i,
   // private write data path
   input  wire logic       wr_byte_valid,
   input  wire logic [7:0] wr_byte,
   output logic            rx_push,
   output logic [7:0]      rx_push_data,
   output logic            tx_loop_push,
   output logic [7:0]      tx_loop_data,
   // private read start
   input  wire logic       rd_req,
   input  wire logic       rd_hdr,
   input  wire logic       hdr_capable,
   input  wire logic       tx_empty,
   output logic            rd_answer,
   output logic            rd_addr_ack,
   output logic            rd_use_fill,
   output logic [7:0]      rd_fill_data,
   output logic            rd_end_at_tbit,
   // status query
   input  wire logic       status_req,
   input  wire logic       status_next,
   output logic            status_valid,
   output logic [7:0]      status_byte,
   // captured commands
   input  wire logic       activity_cmd,
   input  wire logic [1:0] activity_code,
   input  wire logic       rstact_cmd,
   input  wire logic       rstact_direct,
   input  wire logic       rstact_get,
   input  wire logic [7:0] rstact_byte,
   input  wire logic       rst_pattern,
   output logic            reset_action_fire,
   output logic [7:0]      reset_action_code,
   output logic [7:0]      reset_action_get_byte,
   // engine events
   input  wire logic [7:0] ev1,
   input  wire logic       ibi_acked,
   input  wire logic       ibi_has_payload,
   input  wire logic       ibi_payload_end,
   input  wire logic [7:0] ev2,
   input  wire logic [7:0] ev3,
   // interrupt
   output logic            irq
);

   function automatic logic [7:0] flag_next(input logic [7:0] cur, input logic [7:0] clr,
                                            input logic [7:0] evt, input logic [7:0] keep);
      // set wins over a clear landing in the same cycle
      flag_next = ((cur & ~clr) | evt) & keep;
   endfunction

   // ---------------- apb decode
   logic [5:0]  idx;
   logic        acc;
   logic        wr_en;
   logic [7:0]  wb;
   logic        mapped;
   assign idx    = paddr[7:2];
   assign acc    = psel & penable;
   // write lands on the edge where the master sees pready high
   assign wr_en  = acc & pwrite & pready;
   assign wb     = pwdata[7:0];
   assign mapped = (idx >= IDX_RESP) && (idx <= IDX_FORCE3);

   logic [7:0] resp_q, stat_hi_q, stat_lo_q, act_q, rst_byte_q, rst_origin_q, rst_direct_q;
   logic [7:0] flags1_q, flags2_q, flags3_q, mask1_q, mask2_q, mask3_q;

   // one wait state so that read data also comes from a flop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else if (ce) begin
         pready  <= acc & ~pready;
         pslverr <= acc & ~pready & ~mapped;
         if (acc && !pready) begin
            case (idx)
               IDX_RESP:       prdata <= {24'h00_0000, resp_q};
               IDX_STAT_HI:    prdata <= {24'h00_0000, stat_hi_q};
               IDX_STAT_LO:    prdata <= {24'h00_0000, stat_lo_q};
               IDX_ACT:        prdata <= {24'h00_0000, act_q};
               IDX_RST_BYTE:   prdata <= {24'h00_0000, rst_byte_q};
               IDX_RST_ORIGIN: prdata <= {24'h00_0000, rst_origin_q};
               IDX_RST_DIRECT: prdata <= {24'h00_0000, rst_direct_q};
               IDX_FLAGS1:     prdata <= {24'h00_0000, flags1_q};
               IDX_MASK1:      prdata <= {24'h00_0000, mask1_q};
               IDX_FLAGS2:     prdata <= {24'h00_0000, flags2_q};
               IDX_MASK2:      prdata <= {24'h00_0000, mask2_q};
               IDX_FLAGS3:     prdata <= {24'h00_0000, flags3_q};
               IDX_MASK3:      prdata <= {24'h00_0000, mask3_q};
               default:        prdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   // ---------------- software control registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         resp_q    <= 8'h00;
         stat_hi_q <= 8'h00;
         stat_lo_q <= 8'h00;
         mask1_q   <= 8'h00;
         mask2_q   <= 8'h00;
         mask3_q   <= 8'h00;
      end else if (ce && wr_en) begin
         case (idx)
            IDX_RESP:    resp_q    <= wb & RESP_MASK;
            IDX_STAT_HI: stat_hi_q <= wb;
            IDX_STAT_LO: stat_lo_q <= wb & STAT_LO_MASK;
            IDX_MASK1:   mask1_q   <= wb & GRP1_MASK;
            IDX_MASK2:   mask2_q   <= wb & GRP2_MASK;
            IDX_MASK3:   mask3_q   <= wb & GRP3_MASK;
            default:     ;
         endcase
      end
   end

   // ---------------- private write path
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_push      <= 1'b0;
         rx_push_data <= 8'h00;
         tx_loop_push <= 1'b0;
         tx_loop_data <= 8'h00;
      end else if (ce) begin
         rx_push      <= wr_byte_valid;
         tx_loop_push <= wr_byte_valid & resp_q[RESP_LOOPBACK_BIT];
         if (wr_byte_valid) begin
            rx_push_data <= wr_byte;
            tx_loop_data <= wr_byte;
         end
      end
   end

   // ---------------- private read start
   logic ddr_rd;
   assign ddr_rd = rd_hdr & hdr_capable;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rd_answer      <= 1'b0;
         rd_addr_ack    <= 1'b0;
         rd_use_fill    <= 1'b0;
         rd_fill_data   <= 8'h00;
         rd_end_at_tbit <= 1'b0;
      end else if (ce) begin
         rd_answer <= rd_req;
         if (rd_req) begin
            rd_addr_ack    <= ~(tx_empty & resp_q[RESP_NAK_BIT]);
            rd_use_fill    <= tx_empty & ~resp_q[RESP_NAK_BIT];
            rd_fill_data   <= ddr_rd ? DDR_EMPTY_FILL : SDR_EMPTY_FILL;
            rd_end_at_tbit <= tx_empty & ~resp_q[RESP_NAK_BIT] & ~ddr_rd;
         end
      end
   end

   // ---------------- status query bytes, high first
   logic status_second_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_valid    <= 1'b0;
         status_byte     <= 8'h00;
         status_second_q <= 1'b0;
      end else if (ce) begin
         if (status_req) begin
            status_valid    <= 1'b1;
            status_byte     <= stat_hi_q;
            status_second_q <= 1'b1;
         end else if (status_next && status_valid) begin
            status_valid    <= status_second_q;
            status_byte     <= status_second_q ? stat_lo_q : 8'h00;
            status_second_q <= 1'b0;
         end
      end
   end

   // ---------------- captured commands
   logic armed_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         act_q             <= 8'h00;
         rst_byte_q        <= 8'h00;
         rst_origin_q      <= 8'h00;
         rst_direct_q      <= RST_DIRECT_RESET;
         armed_q           <= 1'b0;
         reset_action_fire <= 1'b0;
      end else if (ce) begin
         if (activity_cmd)
            act_q <= {6'h00, activity_code};
         if (rstact_cmd) begin
            rst_byte_q   <= rstact_byte;
            rst_origin_q <= {6'h00, rstact_direct & rstact_get, rstact_direct};
            if (rstact_direct && !rstact_get)
               rst_direct_q <= rstact_byte;
         end
         // action only after a reset action command has been seen
         reset_action_fire <= rst_pattern & armed_q;
         if (rstact_cmd)
            armed_q <= 1'b1;
         else if (rst_pattern)
            armed_q <= 1'b0;
      end
   end
   assign reset_action_code     = rst_byte_q;
   assign reset_action_get_byte = rst_direct_q;

   // ---------------- bus condition detector on synchronised pins
   logic [1:0]  scl_sync_q, sda_sync_q;
   logic [15:0] high_cnt_q;
   logic        aval_evt, idle_evt;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scl_sync_q <= 2'b00;
         sda_sync_q <= 2'b00;
         high_cnt_q <= 16'h0000;
      end else if (ce) begin
         scl_sync_q <= {scl_sync_q[0], scl_i};
         sda_sync_q <= {sda_sync_q[0], sda_i};
         if (!(scl_sync_q[1] && sda_sync_q[1]))
            high_cnt_q <= 16'h0000;
         else if (high_cnt_q != 16'hFFFF)
            high_cnt_q <= high_cnt_q + 16'h0001;
      end
   end
   assign aval_evt = ce && scl_sync_q[1] && sda_sync_q[1] && (high_cnt_q == 16'(AVAL_CYC - 1));
   assign idle_evt = ce && scl_sync_q[1] && sda_sync_q[1] && (high_cnt_q == 16'(IDLE_CYC - 1));

   // ---------------- in-band done waits for payload end
   logic ibi_wait_q;
   logic ibi_done_evt;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         ibi_wait_q <= 1'b0;
      else if (ce) begin
         if (ibi_acked && ibi_has_payload)
            ibi_wait_q <= 1'b1;
         else if (ibi_payload_end)
            ibi_wait_q <= 1'b0;
      end
   end
   assign ibi_done_evt = (ibi_acked & ~ibi_has_payload) | (ibi_wait_q & ibi_payload_end);

   // ---------------- event flags
   logic [7:0] clr1, clr2, clr3, frc1, frc2, frc3, evt1, evt2, evt3;
   assign clr1 = (wr_en && idx == IDX_FLAGS1) ? wb : 8'h00;
   assign clr2 = (wr_en && idx == IDX_FLAGS2) ? wb : 8'h00;
   assign clr3 = (wr_en && idx == IDX_FLAGS3) ? wb : 8'h00;
   assign frc1 = (wr_en && idx == IDX_FORCE1) ? wb : 8'h00;
   assign frc2 = (wr_en && idx == IDX_FORCE2) ? wb : 8'h00;
   assign frc3 = (wr_en && idx == IDX_FORCE3) ? wb : 8'h00;
   // engine drives bits 7:3 and 1:0 of group 1 directly; bit 2 is derived
   assign evt1 = (ev1 & 8'hFB) | {5'h00, ibi_done_evt, 2'b00} | frc1;
   assign evt2 = ev2 | {4'h0, rd_req & tx_empty, 3'b000} | frc2;
   assign evt3 = (ev3 & 8'h88) | frc3 | {1'b0, rst_pattern, rstact_cmd, activity_cmd,
                                          2'b00, aval_evt, idle_evt};
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flags1_q <= 8'h00;
         flags2_q <= 8'h00;
         flags3_q <= 8'h00;
      end else if (ce) begin
         flags1_q <= flag_next(flags1_q, clr1, evt1, GRP1_MASK);
         flags2_q <= flag_next(flags2_q, clr2, evt2, GRP2_MASK);
         flags3_q <= flag_next(flags3_q, clr3, evt3, GRP3_MASK);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         irq <= 1'b0;
      else if (ce)
         irq <= |{flags1_q & mask1_q, flags2_q & mask2_q, flags3_q & mask3_q};
   end

   // ---------------- checks
   AST_LOOP_OFF: assert property (@(posedge pclk) disable iff (!presetn)
      ce && wr_byte_valid && !resp_q[RESP_LOOPBACK_BIT] |=> rx_push && !tx_loop_push)
      else $error("loopback off but byte copied to tx queue");
   AST_LOOP_ON: assert property (@(posedge pclk) disable iff (!presetn)
      ce && wr_byte_valid && resp_q[RESP_LOOPBACK_BIT] |=> tx_loop_push && tx_loop_data == $past(wr_byte))
      else $error("loopback byte not copied");
   AST_SDR_FILL: assert property (@(posedge pclk) disable iff (!presetn)
      ce && rd_req && tx_empty && !resp_q[RESP_NAK_BIT] && !ddr_rd
      |=> rd_addr_ack && rd_use_fill && rd_fill_data == 8'hFF && rd_end_at_tbit)
      else $error("sdr empty read answer wrong");
   AST_DDR_FILL: assert property (@(posedge pclk) disable iff (!presetn)
      ce && rd_req && tx_empty && !resp_q[RESP_NAK_BIT] && ddr_rd
      |=> rd_addr_ack && rd_use_fill && rd_fill_data == 8'h00 && !rd_end_at_tbit)
      else $error("ddr empty read answer wrong");
   AST_NAK_EMPTY: assert property (@(posedge pclk) disable iff (!presetn)
      ce && rd_req && tx_empty && resp_q[RESP_NAK_BIT] |=> rd_answer && !rd_addr_ack)
      else $error("empty read acknowledged with refusal set");
   AST_STATUS_ORDER: assert property (@(posedge pclk) disable iff (!presetn)
      ce && status_req ##1 ce && status_next && !status_req |=> status_byte == $past(stat_lo_q))
      else $error("status low byte not second");
   AST_RST_ORIGIN: assert property (@(posedge pclk) disable iff (!presetn)
      ce && rstact_cmd |=> rst_origin_q[1:0] == {$past(rstact_direct & rstact_get), $past(rstact_direct)})
      else $error("reset action origin flags wrong");
   AST_FIRE_ARMED: assert property (@(posedge pclk) disable iff (!presetn)
      ce && rst_pattern |=> reset_action_fire == $past(armed_q))
      else $error("reset action fire does not follow the armed state");
   AST_IBI_WAIT: assert property (@(posedge pclk) disable iff (!presetn)
      ce && ibi_acked && ibi_has_payload && !ibi_payload_end && !frc1[F1_IBI_DONE] && !ev1[F1_IBI_DONE]
      && !flags1_q[F1_IBI_DONE] |=> !flags1_q[F1_IBI_DONE])
      else $error("in-band done set before payload end");
   AST_SET_WINS: assert property (@(posedge pclk) disable iff (!presetn)
      ce && rd_req && tx_empty && clr2[F2_RD_TX_EMPTY] |=> flags2_q[F2_RD_TX_EMPTY])
      else $error("event lost against clear");
   AST_IRQ_MASK: assert property (@(posedge pclk) disable iff (!presetn)
      ce && ((flags1_q & mask1_q) | (flags2_q & mask2_q) | (flags3_q & mask3_q)) == 8'h00 |=> !irq)
      else $error("interrupt without enabled flag");
   AST_FORCE: assert property (@(posedge pclk) disable iff (!presetn)
      ce && wr_en && idx == IDX_FORCE3 && wb[F3_RSTACT] |=> flags3_q[F3_RSTACT] ##1 !ce || flags3_q[F3_RSTACT]
      || $past(clr3[F3_RSTACT]))
      else $error("force did not set flag");
   AST_PREADY: assert property (@(posedge pclk) disable iff (!presetn)
      ce && acc && !pready |=> pready ##1 (!pready || !ce))
      else $error("apb answer not one wait state");
   COV_LOOP: cover property (@(posedge pclk) disable iff (!presetn) tx_loop_push);
   COV_EMPTY_READ: cover property (@(posedge pclk) disable iff (!presetn) rd_answer && rd_use_fill);
   COV_FIRE: cover property (@(posedge pclk) disable iff (!presetn) reset_action_fire);
   COV_IRQ: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));

endmodule // i3tr_regs

// >>> i3tr_bus_model.sv
// Purpose: pin-level stand-in for the controller on scl and sda
// Assumes: pull-ups hold both lines high outside frames
// Notes:   sda is the inverse of scl in a frame, so both never read high together
`timescale 1ns/100ps
module i3tr_bus_model (
   // frame request from the bench
   input  wire logic frame,
   // bus pins seen by the block
   output logic      scl_i,
   output logic      sda_i
);
   initial begin
      scl_i = 1'b1;
      sda_i = 1'b1;
      // odd start offset puts every toggle 0.5 ns ahead of a pclk rising edge, a fixed phase
      #37;
      forever begin
         #100;
         scl_i = frame ? ~scl_i : 1'b1;
         sda_i = frame ? ~scl_i : 1'b1;
      end
   end
endmodule // i3tr_bus_model

// >>> test_i3c_target_status_irq_regs.sv
// Purpose: self-checking bench of the target status and event register bank
// Assumes: one apb wait state; idle count shortened to 100 cycles
// Notes:   bus pins are toggled by the pin model except in the idle scenario
`timescale 1ns/100ps
module test_i3c_target_status_irq_regs;
   import i3tr_pkg::*;
   logic        pclk, presetn, ce, psel, penable, pwrite, frame, err_q;
   logic        wr_byte_valid, rd_req, rd_hdr, hdr_capable, tx_empty, status_req, status_next;
   logic        activity_cmd, rstact_cmd, rstact_direct, rstact_get, rst_pattern;
   logic        ibi_acked, ibi_has_payload, ibi_payload_end, scl_i, sda_i;
   logic        pready, pslverr, rx_push, tx_loop_push, rd_answer, rd_addr_ack, rd_use_fill;
   logic        rd_end_at_tbit, status_valid, reset_action_fire, irq;
   logic [1:0]  activity_code;
   logic [7:0]  paddr, wr_byte, rstact_byte, ev1, ev2, ev3, rx_push_data, tx_loop_data, q;
   logic [7:0]  rd_fill_data, status_byte, reset_action_code, reset_action_get_byte;
   logic [31:0] pwdata, prdata;
   int          n_fail, samples_checked;

   i3tr_regs #(.IDLE_CYC(100)) dut (.*);
   i3tr_bus_model u_bus (.frame(frame), .scl_i(scl_i), .sda_i(sda_i));

   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end

   task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
      samples_checked++;
      if (s !== e) begin
         n_fail++;
         $display("Error %s expected %h seen %h", nm, e, s);
      end
   endtask

   task automatic test_done;
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   // holds the request until pready is sampled high
   task automatic apb(input logic w, input logic [5:0] ix, input logic [7:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {ix, 2'b00};
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      // no timeout here: if pready never rises only the hang guard ends this wait
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      q = prdata[7:0];
      err_q = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rdc(input string nm, input logic [5:0] ix, input logic [7:0] e);
      apb(1'b0, ix, 8'h00);
      chk(nm, q, e);
   endtask

   task automatic t_regs;
      rdc("rst_direct", IDX_RST_DIRECT, RST_DIRECT_RESET);
      rdc("flags1", IDX_FLAGS1, 8'h00);
      apb(1'b0, 6'h3F, 8'h00);
      chk("slverr", err_q, 1'b1);
      apb(1'b1, IDX_RESP, 8'hFF);
      rdc("resp", IDX_RESP, RESP_MASK);
   endtask

   task automatic t_wr(input logic lb);
      apb(1'b1, IDX_RESP, {3'b0, lb, 4'b0});
      wr_byte <= 8'h5A ^ {7'b0, lb};
      wr_byte_valid <= 1'b1;
      @(posedge pclk);
      wr_byte_valid <= 1'b0;
      #1;
      chk("rx_push", rx_push, 1'b1);
      chk("rx_data", rx_push_data, 8'h5A ^ {7'b0, lb});
      chk("loop_push", tx_loop_push, lb);
      if (lb) chk("loop_data", tx_loop_data, 8'h5B);
   endtask

   // every mix of refusal, ddr, empty and hdr capability
   task automatic t_rd;
      logic e, n, hc;
      for (int i = 0; i < 16; i++) begin
         n = i[0];
         e = i[2];
         hc = i[1] & i[3];
         apb(1'b1, IDX_RESP, {7'b0, n});
         rd_hdr <= i[1];
         hdr_capable <= i[3];
         tx_empty <= e;
         rd_req <= 1'b1;
         @(posedge pclk);
         rd_req <= 1'b0;
         #1;
         chk("answer", rd_answer, 1'b1);
         chk("addr_ack", rd_addr_ack, !(e & n));
         chk("use_fill", rd_use_fill, e & ~n);
         if (e & ~n) chk("fill", rd_fill_data, hc ? 8'h00 : 8'hFF);
         chk("end_tbit", rd_end_at_tbit, e & ~n & ~hc);
         rdc("flags2", IDX_FLAGS2, {4'b0, e, 3'b0});
         apb(1'b1, IDX_FLAGS2, 8'h08);
      end
      // clear and a new empty read on one edge: the event must survive
      fork
         apb(1'b1, IDX_FLAGS2, 8'h08);
         begin
            repeat (3) @(posedge pclk);
            rd_req <= 1'b1;
            @(posedge pclk);
            rd_req <= 1'b0;
         end
      join
      rdc("set_wins", IDX_FLAGS2, 8'h08);
      apb(1'b1, IDX_FLAGS2, 8'h08);
   endtask

   task automatic t_status;
      apb(1'b1, IDX_STAT_HI, 8'hA5);
      apb(1'b1, IDX_STAT_LO, 8'hFF);
      status_req <= 1'b1;
      @(posedge pclk);
      status_req <= 1'b0;
      status_next <= 1'b1;
      #1;
      chk("stat_hi", status_byte, 8'hA5);
      for (int k = 0; k < 2; k++) begin
         @(posedge pclk);
         status_next <= (k == 0);
         #1;
         chk("stat_valid", status_valid, k == 0);
         if (k == 0) chk("stat_lo", status_byte, STAT_LO_MASK);
      end
   endtask

   task automatic t_cmd;
      @(posedge pclk);
      for (int c = 0; c < 4; c++) begin
         activity_code <= 2'(c);
         activity_cmd <= 1'b1;
         @(posedge pclk);
         activity_cmd <= 1'b0;
         rdc("activity", IDX_ACT, 8'(c));
      end
      // broadcast, direct set, direct get
      for (int k = 0; k < 3; k++) begin
         rstact_byte <= 8'((k + 1) * 17);
         rstact_direct <= (k > 0);
         rstact_get <= (k == 2);
         rstact_cmd <= 1'b1;
         @(posedge pclk);
         rstact_cmd <= 1'b0;
         rdc("rst_byte", IDX_RST_BYTE, 8'((k + 1) * 17));
         chk("act_code", reset_action_code, 8'((k + 1) * 17));
         rdc("origin", IDX_RST_ORIGIN, {6'b0, k == 2, k > 0});
         rdc("rst_direct", IDX_RST_DIRECT, k == 0 ? 8'h80 : 8'h22);
         chk("get_byte", reset_action_get_byte, k == 0 ? 8'h80 : 8'h22);
      end
      // second pattern without a new command must not fire
      rst_pattern <= 1'b1;
      for (int k = 0; k < 2; k++) begin
         @(posedge pclk);
         rst_pattern <= (k == 0);
         #1;
         chk("fire", reset_action_fire, k == 0);
      end
      @(posedge pclk);
      ev3 <= 8'h88;
      @(posedge pclk);
      ev3 <= 8'h00;
      rdc("flags3", IDX_FLAGS3, 8'hF8);
      apb(1'b1, IDX_FLAGS3, 8'hF8);
      rdc("flags3", IDX_FLAGS3, 8'h00);
   endtask

   task automatic t_irq;
      logic [5:0] f;
      logic [7:0] m, r;
      ev1 <= 8'hEB;
      ev2 <= 8'hE7;
      @(posedge pclk);
      ev1 <= 8'h00;
      ev2 <= 8'h00;
      rdc("ev_flags1", IDX_FLAGS1, 8'hEB);
      rdc("ev_flags2", IDX_FLAGS2, 8'hE7);
      apb(1'b1, IDX_FLAGS1, 8'hFF);
      apb(1'b1, IDX_FLAGS2, 8'hFF);
      for (int g = 0; g < 3; g++) begin
         f = IDX_FLAGS1 + 6'(3 * g);
         m = (g == 2) ? GRP3_MASK : GRP1_MASK;
         r = m;
         apb(1'b1, f + 6'd2, 8'hFF);
         rdc("forced", f, m);
         chk("irq_masked", irq, 1'b0);
         for (int b = 0; b < 8; b++) begin
            if (m[b]) begin
               apb(1'b1, f + 6'd1, 8'(1 << b));
               @(posedge pclk);
               #1;
               chk("irq_on", irq, 1'b1);
               apb(1'b1, f, 8'(1 << b));
               r[b] = 1'b0;
               rdc("w1c", f, r);
               @(posedge pclk);
               #1;
               chk("irq_off", irq, 1'b0);
            end
         end
         apb(1'b1, f + 6'd1, 8'h00);
      end
   endtask

   task automatic t_ibi;
      for (int p = 1; p >= 0; p--) begin
         ibi_has_payload <= p[0];
         ibi_acked <= 1'b1;
         @(posedge pclk);
         ibi_acked <= 1'b0;
         if (p) rdc("ibi_wait", IDX_FLAGS1, 8'h00);
         ibi_payload_end <= p[0];
         @(posedge pclk);
         ibi_payload_end <= 1'b0;
         rdc("ibi_done", IDX_FLAGS1, 8'h04);
         apb(1'b1, IDX_FLAGS1, 8'h04);
      end
   endtask

   task automatic t_idle;
      apb(1'b1, IDX_FLAGS3, 8'h03);
      frame <= 1'b0;
      repeat (30) @(posedge pclk);
      rdc("not_yet", IDX_FLAGS3, 8'h00);
      repeat (20) @(posedge pclk);
      rdc("available", IDX_FLAGS3, 8'h02);
      repeat (60) @(posedge pclk);
      rdc("idle", IDX_FLAGS3, 8'h03);
   endtask

   initial begin
      {presetn, psel, penable, pwrite, wr_byte_valid, rd_req, rd_hdr, hdr_capable, tx_empty} = '0;
      {status_req, status_next, activity_cmd, rstact_cmd, rstact_direct, rstact_get} = '0;
      {rst_pattern, ibi_acked, ibi_has_payload, ibi_payload_end, activity_code} = '0;
      {paddr, wr_byte, rstact_byte, ev1, ev2, ev3, pwdata} = '0;
      {n_fail, samples_checked} = '0;
      ce = 1'b1;
      frame = 1'b1;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      t_regs;
      t_wr(1'b0);
      t_wr(1'b1);
      t_rd;
      t_status;
      t_cmd;
      t_irq;
      t_ibi;
      t_idle;
      test_done;
   end

   // hang guard, well above the fewer than one thousand cycles the run needs
   initial begin
      repeat (20000) @(posedge pclk);
      n_fail++;
      test_done;
   end
endmodule // test_i3c_target_status_irq_regs
